//--- hw/usf_spi_port.sv
// Function
// R1: Mode bit 0 selects SPI; role bit selects master or slave.
// R2: Master: data buffer write starts byte; SCK from baud, MOSI out, MISO in.
// R3: Active high during transfer; master sets transmit-done at end.
// R4: Polarity, phase and bit order follow generic control settings.
// R5: Order 0 LSB first; phase 0 outputs on return edge, samples leading.
// R6: Master: received byte placed in data buffer, receive interrupt raised.
// R7: Master transmit interrupt fires at transfer start, ahead of receive.
// R8: Host writes data buffer only after transmit-done reads 1.
// R9: Back-to-back DMA transmits need phase zero, else poll transmit-done.
// R10: Master uses three wires and ignores select input.
// R11: Slave takes SCK as input, shifts MOSI in and MISO out.
// R12: Slave byte completion sets receive-ready, receive interrupt, readable byte.
// R13: Slave transmit interrupt raised at start of each byte.
// R14: Select fall activates slave; rise deactivates, MISO stays driven.
// R15: External master releases select only at byte boundaries.
// R16: Bit rate is (256+mantissa)*2^exponent/2^28 times system clock.
// R17: Top asynchronous rate is clock/16 at exponent 16, mantissa 0.
// R18: Master SCK up to clock/8, transmit-only clock/2; slave clock/8.
// R19: Host programs mantissa and exponent before any serial operation.
// R20: At 32 MHz, 216/11 gives 115200 and 59/8 gives 9600.
// R21: Flush aborts and clears buffers at once; bit timer keeps running.
// R22: Flush reads 0 and acts only when written with 1.
// R23: Receive and transmit complete events give interrupts and DMA triggers.
// R24: Role bit 0 is master, 1 is slave, reset value 0.
// R25: Reset idles shift logic, baud timer and clears status flags.
`timescale 1ns/10ps

// --------------------------------------------------------------------
// Transmit FIFO
// --------------------------------------------------------------------
module usf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input logic clk,
   input logic rst_n,
   input logic flush,
   input logic in_valid,
   output logic in_ready,
   input logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [AW:0] count;
   logic [AW:0] next_count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_data = mem[rd_idx];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_idx] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
      end else if (flush) begin
         wr_idx <= '0;
         rd_idx <= '0;
         count <= '0;
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         wr_idx <= wr_idx + AW'(push);
         rd_idx <= rd_idx + AW'(pop);
         count <= next_count;
         in_ready <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end
endmodule : usf_fifo

// --------------------------------------------------------------------
// SPI port
// --------------------------------------------------------------------
module usf_spi_port (
   input logic CORE_CLK,
   input logic NRST,
   input logic MODE_SEL,
   input logic SLAVE_SEL,
   input logic CLOCK_POLARITY,
   input logic CLOCK_PHASE,
   input logic BIT_ORDER,
   input logic [7:0] BAUD_M,
   input logic [4:0] BAUD_E,
   input logic FLUSH,
   input logic [7:0] TX_DATA,
   input logic TX_VALID,
   output logic TX_READY,
   input logic TX_BYTE_CLR,
   input logic RD_STROBE,
   output logic [7:0] RD_DATA,
   output logic ACTIVE,
   output logic TX_BYTE,
   output logic RX_BYTE,
   output logic TX_COMPLETE_IRQ,
   output logic RX_COMPLETE_IRQ,
   output logic DMA_TX_TRIG,
   output logic DMA_RX_TRIG,
   input logic SCK_IN,
   output logic SCK_OUT,
   output logic SCK_OE,
   input logic MOSI_IN,
   output logic MOSI_OUT,
   output logic MOSI_OE,
   input logic MISO_IN,
   output logic MISO_OUT,
   output logic MISO_OE,
   input logic SELECT_IN
);
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                           input logic msb);
      shift_in = msb ? {v[6:0], b} : {b, v[7:1]};
   endfunction : shift_in

   function automatic logic out_bit(input logic [7:0] v, input logic msb);
      out_bit = msb ? v[7] : v[0];
   endfunction : out_bit

   // -----------------------------------------------------------------
   // Reset release
   // -----------------------------------------------------------------
   logic [1:0] rst_sync;
   wire rst_n = rst_sync[1];

   always_ff @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // -----------------------------------------------------------------
   // Configuration
   // -----------------------------------------------------------------
   usf_pkg::usf_cfg_s cfg;
   assign cfg = '{clock_polarity: CLOCK_POLARITY, clock_phase: CLOCK_PHASE, msb_first: BIT_ORDER,
                  baud_m: BAUD_M, baud_e: BAUD_E};  // R4 R5
   wire spi_on = MODE_SEL == usf_pkg::MODE_SPI;  // R1
   wire slave = SLAVE_SEL == usf_pkg::ROLE_SLAVE;  // R24

   // -----------------------------------------------------------------
   // Baud generator, two ticks per bit
   // -----------------------------------------------------------------
   logic [26:0] acc;
   wire [8:0] baud_base = usf_pkg::BAUD_BASE + {1'b0, cfg.baud_m};  // R16
   wire [27:0] baud_inc = {19'h00000, baud_base} << cfg.baud_e;  // R16 R17 R18 R20
   wire [27:0] baud_sum = {1'b0, acc} + baud_inc;
   wire tick = baud_sum[27];

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         acc <= usf_pkg::ACC_RESET;  // R25
      end else begin
         acc <= baud_sum[26:0];  // R21
      end
   end

   // -----------------------------------------------------------------
   // Shift engine decode
   // -----------------------------------------------------------------
   usf_pkg::usf_state_e state;
   usf_pkg::usf_state_e next_state;
   logic [7:0] sr;
   logic [7:0] next_sr;
   logic [3:0] k;
   logic latch;
   logic sck_prev;
   logic sel_prev;
   logic sel_act;
   logic fifo_valid;
   logic [7:0] fifo_data;

   wire idle = state == usf_pkg::ST_IDLE;
   wire shifting = state == usf_pkg::ST_SHIFT;
   wire sel_fall = slave && sel_prev && !SELECT_IN;  // R14
   wire sel_rise = slave && !sel_prev && SELECT_IN;  // R14
   wire slv_edge = sel_act && (SCK_IN != sck_prev);  // R11
   wire ev = shifting && (slave ? slv_edge : tick);  // R2 R11
   wire in_bit = slave ? MOSI_IN : MISO_IN;
   wire is_sample = k[0] == cfg.clock_phase;  // R5
   wire last = k == usf_pkg::EDGE_LAST;
   wire start_m = spi_on && !slave && idle && fifo_valid && !FLUSH;  // R2 R10
   wire start_s = spi_on && slave && idle && sel_act && !FLUSH;  // R14
   wire start = start_m || start_s;
   wire pop = start_m || (start_s && fifo_valid);
   wire [7:0] load = fifo_valid ? fifo_data : usf_pkg::DATA_RESET;
   wire skip_shift = cfg.clock_phase && (k == usf_pkg::EDGE_FIRST);
   wire shift_ev = ev && !is_sample && !skip_shift;
   wire final_samp = ev && is_sample && last && cfg.clock_phase;
   wire done = (shift_ev && last) || final_samp;
   wire do_flush = FLUSH;  // R22

   assign next_sr = do_flush ? usf_pkg::DATA_RESET :
                    start ? load :
                    final_samp ? shift_in(sr, in_bit, cfg.msb_first) :
                    shift_ev ? shift_in(sr, latch, cfg.msb_first) : sr;  // R5

   assign next_state = (do_flush || !spi_on) ? usf_pkg::ST_IDLE :
                       start ? usf_pkg::ST_SHIFT :
                       done ? usf_pkg::ST_DONE :
                       (state == usf_pkg::ST_DONE) ? usf_pkg::ST_IDLE : state;

   usf_fifo #(.WIDTH(usf_pkg::DATA_W), .DEPTH(usf_pkg::FIFO_DEPTH)) u_fifo (
      .clk(CORE_CLK),
      .rst_n(rst_n),
      .flush(do_flush),
      .in_valid(TX_VALID),
      .in_ready(TX_READY),
      .in_data(TX_DATA),
      .out_valid(fifo_valid),
      .out_ready(pop),
      .out_data(fifo_data)
   );

   // -----------------------------------------------------------------
   // Shift engine state
   // -----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         state <= usf_pkg::ST_IDLE;  // R25
         sr <= usf_pkg::DATA_RESET;
         k <= usf_pkg::EDGE_FIRST;
         latch <= 1'b0;
      end else begin
         state <= next_state;
         sr <= next_sr;
         k <= (start || do_flush) ? usf_pkg::EDGE_FIRST : ev ? k + 4'h1 : k;
         latch <= (ev && is_sample) ? in_bit : latch;  // R5
      end
   end

   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sck_prev <= 1'b0;
         sel_prev <= usf_pkg::SELECT_IDLE;
         sel_act <= 1'b0;
      end else begin
         sck_prev <= SCK_IN;
         sel_prev <= SELECT_IN;
         sel_act <= slave && spi_on && (sel_fall || (sel_act && !sel_rise));  // R14 R15
      end
   end

   // -----------------------------------------------------------------
   // Pins
   // -----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         SCK_OUT <= 1'b0;
         SCK_OE <= 1'b0;
         MOSI_OUT <= 1'b0;
         MOSI_OE <= 1'b0;
         MISO_OUT <= 1'b0;
         MISO_OE <= 1'b0;
      end else begin
         SCK_OUT <= (shifting && !slave) ? (SCK_OUT ^ ev) : cfg.clock_polarity;  // R2 R4
         SCK_OE <= spi_on && !slave;  // R10 R11
         MOSI_OUT <= final_samp ? MOSI_OUT : out_bit(next_sr, cfg.msb_first);  // R2 R5
         MOSI_OE <= spi_on && !slave;  // R10
         MISO_OUT <= out_bit(next_sr, cfg.msb_first);  // R11
         MISO_OE <= spi_on && slave && (MISO_OE || sel_fall);  // R14
      end
   end

   // -----------------------------------------------------------------
   // Status, data buffer and events
   // -----------------------------------------------------------------
   always_ff @(posedge CORE_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ACTIVE <= 1'b0;  // R25
         TX_BYTE <= 1'b0;
         RX_BYTE <= 1'b0;
         RD_DATA <= usf_pkg::DATA_RESET;
         TX_COMPLETE_IRQ <= 1'b0;
         RX_COMPLETE_IRQ <= 1'b0;
         DMA_TX_TRIG <= 1'b0;
         DMA_RX_TRIG <= 1'b0;
      end else begin
         ACTIVE <= next_state == usf_pkg::ST_SHIFT;  // R3
         TX_BYTE <= (done && !slave) || (TX_BYTE && !TX_BYTE_CLR);  // R3 R8
         RX_BYTE <= (done && slave) || (RX_BYTE && !RD_STROBE);  // R12
         RD_DATA <= do_flush ? usf_pkg::DATA_RESET : done ? next_sr : RD_DATA;  // R6 R12 R21
         TX_COMPLETE_IRQ <= start;  // R7 R13
         RX_COMPLETE_IRQ <= done;  // R6 R12
         DMA_TX_TRIG <= start;  // R23
         DMA_RX_TRIG <= done;  // R23
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   property p_tx_irq_start;
      @(posedge CORE_CLK) disable iff (!rst_n)
      start |=> TX_COMPLETE_IRQ && ACTIVE ##1 !TX_COMPLETE_IRQ;
   endproperty
   a_tx_irq_start: assert property (p_tx_irq_start) else $error("tx irq not at start"); // R7

   property p_master_done;
      @(posedge CORE_CLK) disable iff (!rst_n)
      (done && !slave) |=> RX_COMPLETE_IRQ && TX_BYTE && !ACTIVE && RD_DATA == $past(next_sr);
   endproperty
   a_master_done: assert property (p_master_done) else $error("master end wrong"); // R3

   property p_slave_done;
      @(posedge CORE_CLK) disable iff (!rst_n)
      (done && slave) |=> RX_BYTE && RX_COMPLETE_IRQ;
   endproperty
   a_slave_done: assert property (p_slave_done) else $error("slave byte not flagged"); // R12

   property p_dma_match;
      @(posedge CORE_CLK) disable iff (!rst_n)
      DMA_RX_TRIG == RX_COMPLETE_IRQ && DMA_TX_TRIG == TX_COMPLETE_IRQ;
   endproperty
   a_dma_match: assert property (p_dma_match) else $error("dma trigger differs"); // R23

   property p_flush_idle;
      @(posedge CORE_CLK) disable iff (!rst_n)
      FLUSH |=> !ACTIVE && !fifo_valid && RD_DATA == usf_pkg::DATA_RESET;
   endproperty
   a_flush_idle: assert property (p_flush_idle) else $error("flush left state"); // R21

   property p_slave_no_drive;
      @(posedge CORE_CLK) disable iff (!rst_n)
      (spi_on && slave) |=> !SCK_OE && !MOSI_OE;
   endproperty
   a_slave_no_drive: assert property (p_slave_no_drive) else $error("slave drives sck"); // R11

   property p_miso_kept;
      @(posedge CORE_CLK) disable iff (!rst_n)
      (MISO_OE && slave && spi_on && $stable(SLAVE_SEL)) |=> MISO_OE;
   endproperty
   a_miso_kept: assert property (p_miso_kept) else $error("miso released"); // R14

   property p_edge_count;
      @(posedge CORE_CLK) disable iff (!rst_n)
      (done && !slave) |-> k == usf_pkg::EDGE_LAST && $past(state) == usf_pkg::ST_SHIFT;
   endproperty
   a_edge_count: assert property (p_edge_count) else $error("byte not 16 edges"); // R2

   property p_sck_idle;
      @(posedge CORE_CLK) disable iff (!rst_n)
      (idle && !slave) ##1 $stable(CLOCK_POLARITY) |-> SCK_OUT == CLOCK_POLARITY;
   endproperty
   a_sck_idle: assert property (p_sck_idle) else $error("sck idle level"); // R4
endmodule : usf_spi_port

//--- shared/usf_pkg.sv
package usf_pkg;
   // ----------------------------------------------------------------
   // Widths and depths
   // ----------------------------------------------------------------
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int BAUD_M_W = 8;
   localparam int BAUD_E_W = 5;
   localparam int BAUD_ACC_W = 27;
   localparam int BAUD_INC_W = 28;
   // ----------------------------------------------------------------
   // Encodings and reset values
   // ----------------------------------------------------------------
   localparam logic MODE_SPI = 1'b0;
   localparam logic ROLE_SLAVE = 1'b1;
   localparam logic SELECT_IDLE = 1'b1;
   localparam logic [8:0] BAUD_BASE = 9'h100;
   localparam logic [3:0] EDGE_FIRST = 4'h0;
   localparam logic [3:0] EDGE_LAST = 4'hF;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam logic [26:0] ACC_RESET = 27'h0000000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_DONE = 2'b11
   } usf_state_e;

   typedef struct packed {
      logic clock_polarity;
      logic clock_phase;
      logic msb_first;
      logic [BAUD_M_W-1:0] baud_m;
      logic [BAUD_E_W-1:0] baud_e;
   } usf_cfg_s;
endpackage : usf_pkg

//--- verif/usf_spi_peer.sv
`timescale 1ns/10ps
// ----
// Far-side slave device
// ----
module usf_spi_peer (
   input wire logic clk,
   input wire logic clr,
   input wire logic sck,
   input wire logic mosi,
   output logic miso,
   input wire logic clock_polarity,
   input wire logic clock_phase,
   input wire logic msb_first,
   input wire logic [7:0] reply,
   output logic [7:0] got,
   output logic [7:0] edges,
   output logic [7:0] gap,
   output logic uneven
);
   logic sck_q;
   logic [7:0] cnt;
   logic [2:0] idx = 3'h0;
   // Three wires only, no select line
   assign miso = msb_first ? reply[3'h7 - idx] : reply[idx];
   always @(posedge clk) begin
      sck_q <= sck;
      cnt <= cnt + 8'h01;
      if (clr) begin
         edges <= 8'h00;
         idx <= 3'h0;
         uneven <= 1'b0;
      end else if (sck != sck_q) begin
         edges <= edges + 8'h01;
         cnt <= 8'h01;
         gap <= cnt;
         if (edges > 8'h01 && cnt != gap) uneven <= 1'b1;
         if ((sck != clock_polarity) ^ clock_phase) begin
            got <= msb_first ? {got[6:0], mosi} : {mosi, got[7:1]};
            idx <= idx + 3'h1;
         end
      end
   end
endmodule : usf_spi_peer

//--- verif/usf_spi_port_test.sv
`timescale 1ns/10ps
// ----
// Bench
// ----
module usf_spi_port_test;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic mode_sel = 1'b0;
   logic slave_sel = 1'b0;
   logic clock_polarity = 1'b0;
   logic clock_phase = 1'b0;
   logic order = 1'b0;
   logic [4:0] baud_e = 5'h11;
   logic [7:0] baud_m = 8'h00;
   logic flush = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic tx_valid = 1'b0;
   logic tx_clr = 1'b0;
   logic rd_strobe = 1'b0;
   logic sck_in = 1'b0;
   logic mosi_in = 1'b0;
   logic select_n = 1'b1;
   logic peer_clr = 1'b0;
   logic [7:0] reply = 8'h00;
   logic tx_ready, active, tx_byte, rx_byte, tx_irq, rx_irq, dma_tx, dma_rx, ok;
   logic sck_out, sck_oe, mosi_out, mosi_oe, miso, miso_out, miso_oe, uneven;
   logic [7:0] rd_data, got, edges, gap, seen;
   int err_count = 0;
   int cmp_count = 0;
   int cyc = 0;
   int tx_n = 0;
   int rx_n = 0;
   int dtx_n = 0;
   int drx_n = 0;
   int tx_at = 0;
   int rx_at = 0;
   int i, k, t0, half;

   usf_spi_port uut (
      .CORE_CLK(clk), .NRST(nrst), .MODE_SEL(mode_sel), .SLAVE_SEL(slave_sel),
      .CLOCK_POLARITY(clock_polarity), .CLOCK_PHASE(clock_phase), .BIT_ORDER(order), .BAUD_M(baud_m),
      .BAUD_E(baud_e), .FLUSH(flush), .TX_DATA(tx_data), .TX_VALID(tx_valid),
      .TX_READY(tx_ready), .TX_BYTE_CLR(tx_clr), .RD_STROBE(rd_strobe), .RD_DATA(rd_data),
      .ACTIVE(active), .TX_BYTE(tx_byte), .RX_BYTE(rx_byte), .TX_COMPLETE_IRQ(tx_irq),
      .RX_COMPLETE_IRQ(rx_irq), .DMA_TX_TRIG(dma_tx), .DMA_RX_TRIG(dma_rx),
      .SCK_IN(sck_in), .SCK_OUT(sck_out), .SCK_OE(sck_oe), .MOSI_IN(mosi_in),
      .MOSI_OUT(mosi_out), .MOSI_OE(mosi_oe), .MISO_IN(miso), .MISO_OUT(miso_out),
      .MISO_OE(miso_oe), .SELECT_IN(select_n)
   );

   usf_spi_peer peer (
      .clk(clk), .clr(peer_clr), .sck(sck_out), .mosi(mosi_out), .miso(miso),
      .clock_polarity(clock_polarity), .clock_phase(clock_phase), .msb_first(order), .reply(reply), .got(got),
      .edges(edges), .gap(gap), .uneven(uneven)
   );

   initial forever #4 clk = ~clk;

   always @(posedge clk) begin
      cyc <= cyc + 1;
      tx_n <= tx_n + int'(tx_irq);
      rx_n <= rx_n + int'(rx_irq);
      dtx_n <= dtx_n + int'(dma_tx);
      drx_n <= drx_n + int'(dma_rx);
      if (tx_irq) tx_at <= cyc;
      if (rx_irq) rx_at <= cyc;
   end

   task automatic check(input logic [7:0] s, input logic [7:0] w);
      cmp_count++;
      if (s !== w) begin
         err_count++;
         $display("BAD %0t saw %h want %h", $time, s, w);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic conclude;
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude

   // Holds the write until it is taken or gives up
   task automatic push(input logic [7:0] b, output logic taken);
      tx_data <= b;
      tx_valid <= 1'b1;
      taken = 1'b0;
      for (int n = 0; n < 8 && !taken; n++) begin
         @(posedge clk);
         taken = tx_ready;
      end
      tx_valid <= 1'b0;
      @(posedge clk);
   endtask : push

   // One byte as external master at the full allowed edge rate, four clocks per edge
   task automatic sbyte(input logic [7:0] b, output logic [7:0] m);
      m = 8'h00;
      for (int n = 0; n < 8; n++) begin
         if (clock_phase) sck_in <= !sck_in;
         mosi_in <= order ? b[7 - n] : b[n];
         tick(4);
         sck_in <= !sck_in;
         m = order ? {m[6:0], miso_out} : {miso_out, m[7:1]};
         tick(4);
         if (!clock_phase) sck_in <= !sck_in;
      end
   endtask : sbyte

   initial begin
      tick(40000);
      err_count++;
      conclude();
   end

   initial begin
      tick(10);
      nrst <= 1'b1;
      tick(5);
      check(active, 1'b0);
      check({tx_byte, rx_byte, tx_ready}, 8'h01);
      for (i = 0; i < 16; i++) begin
         {clock_polarity, clock_phase, order} <= 3'(i);
         baud_e <= i[3] ? 5'h10 : 5'h11;
         select_n <= i[0];
         reply <= 8'hC3 ^ 8'(i * 37);
         tick(80);
         peer_clr <= 1'b1;
         tick(1);
         peer_clr <= 1'b0;
         tick(1);
         half = 4 << (17 - baud_e);
         check(sck_out, clock_polarity);
         check({6'h00, sck_oe, mosi_oe}, 8'h03);
         t0 = rx_n;
         push(8'h5A + 8'(i), ok);
         tick(3);
         check(active, 1'b1);
         for (k = 0; k < 3000 && rx_n == t0; k++) @(posedge clk);
         check(8'(rx_n - t0), 8'h01);
         check(got, 8'h5A + 8'(i));
         check(rd_data, reply);
         check({tx_byte, active}, 8'h02);
         check(edges, 8'h10);
         check(gap, 8'(half));
         check(uneven, 1'b0);
         check(8'((rx_at - tx_at + half) / (2 * half)), 8'h08);
         tx_clr <= 1'b1;
         tick(1);
         tx_clr <= 1'b0;
         tick(2);
         check(tx_byte, 1'b0);
      end
      mode_sel <= 1'b1;
      t0 = tx_n;
      push(8'h55, ok);
      tick(100);
      check(active, 1'b0);
      check(8'(tx_n - t0), 8'h00);
      flush <= 1'b1;
      tick(1);
      flush <= 1'b0;
      mode_sel <= 1'b0;
      tick(100);
      check(8'(tx_n - t0), 8'h00);
      push(8'h77, ok);
      push(8'h78, ok);
      check(active, 1'b1);
      flush <= 1'b1;
      tick(1);
      flush <= 1'b0;
      tick(2);
      check(active, 1'b0);
      check(rd_data, 8'h00);
      t0 = tx_n;
      tick(200);
      check(8'(tx_n - t0), 8'h00);
      baud_m <= 8'h80;
      baud_e <= 5'h0F;
      tick(20);
      t0 = rx_n;
      push(8'hA5, ok);
      for (k = 0; k < 3000 && rx_n == t0; k++) @(posedge clk);
      check(8'(rx_n - t0), 8'h01);
      check(8'((rx_at - tx_at) / 16), 8'h0A);
      slave_sel <= 1'b1;
      {clock_polarity, clock_phase, order} <= 3'h7;
      sck_in <= 1'b1;
      tick(4);
      for (k = 0; k < 5; k++) begin
         push(8'h21 * 8'(k + 1), ok);
         check(ok, k < 4);
      end
      check(tx_ready, 1'b0);
      t0 = tx_n;
      select_n <= 1'b0;
      tick(6);
      check(8'(tx_n - t0), 8'h01);
      check(tx_ready, 1'b1);
      check({5'h00, sck_oe, mosi_oe, miso_oe}, 8'h01);
      for (k = 0; k < 5; k++) begin
         t0 = tx_n;
         i = rx_n;
         sbyte(8'h96 ^ 8'(k), seen);
         tick(8);
         check(seen, k < 4 ? 8'h21 * 8'(k + 1) : 8'h00);
         check(rd_data, 8'h96 ^ 8'(k));
         check(rx_byte, 1'b1);
         check(8'(rx_n - i), 8'h01);
         check(8'(tx_n - t0), 8'h01);
         rd_strobe <= 1'b1;
         tick(1);
         rd_strobe <= 1'b0;
         tick(2);
         check(rx_byte, 1'b0);
      end
      select_n <= 1'b1;
      i = rx_n;
      repeat (20) begin
         sck_in <= !sck_in;
         tick(4);
      end
      check(8'(rx_n - i), 8'h00);
      check(miso_oe, 1'b1);
      check(8'(dtx_n - tx_n), 8'h00);
      check(8'(drx_n - rx_n), 8'h00);
      conclude();
   end
endmodule : usf_spi_port_test
